// ### embpt_pkg.sv
package embpt_pkg;

  // ==========================================
  // sizes
  localparam int NMC  = 16;
  localparam int NPT  = 32;
  localparam int NFB  = 9;
  localparam int MEMB = 2048;

  // ==========================================
  // register byte addresses
  localparam logic [11:0] A_CTRL  = 12'h000;
  localparam logic [11:0] A_MCFG  = 12'h040;
  localparam logic [11:0] A_STAT  = 12'h080;
  localparam logic [11:0] A_PTM   = 12'h100;
  localparam logic [11:0] A_PTEND = 12'h300;
  localparam logic [5:0]  PT_BASE = 6'h10;
  localparam logic [2:0]  WID_MAX = 3'h4;
  localparam logic [4:0]  WID_16  = 5'h10;
  localparam int          CTRL_W  = 13;
  localparam int          MCFG_W  = 12;

  // ==========================================
  // register encodings
  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} embpt_ff_t;

  typedef struct packed {
    logic [1:0] fall;
    logic       deep;
    logic [1:0] page;
    logic [1:0] inv;
    logic       oreg;
    logic       io;
    logic [2:0] wid;
    logic       mem;
  } embpt_ctrl_t;

  typedef struct packed {
    logic       xr;
    logic       pass;
    logic       take;
    logic       exb;
    logic       exa;
    logic       inv;
    logic [1:0] clr;
    logic       clk;
    embpt_ff_t  ff;
    logic       seq;
  } embpt_mcfg_t;

  // ==========================================
  // whole block state
  typedef struct packed {
    embpt_ctrl_t                ctrl;
    embpt_mcfg_t [15:0]         mcfg;
    logic [31:0][2:0][31:0]     ptm;
    logic [1:0]                 clk_prev;
    logic [15:0]                mc_q;
    logic [2047:0]              mem;
    logic [10:0]                wr_addr;
    logic [15:0]                wr_data;
    logic                       wr_go;
    logic [10:0]                rd_addr;
    logic [1:0]                 rd_page;
    logic [15:0]                rd_word;
    logic [15:0]                dout;
    logic [15:0]                blk_out;
    logic                       blk_oe_n;
    logic [9:0]                 local_out;
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;
  } embpt_state_t;

endpackage : embpt_pkg

// ### embpt_block.sv
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Function
// - sixteen macrocells, two product terms each
// - 32 inputs plus nine fed back outputs
// - macrocell may bypass its register
// - register acts as D, T, JK or SR
// - terms go local or to expander; one invertible
// - one of two clocks, with its enable
// - each clock has its own capture edge
// - two invertible clears, each cell picks one
// - up to 32 terms through expanders
// - at most 15 chained sets of two
// - memory widths 16, 8, 4, 2, 1
// - self-timed write from clocked inputs
// - input registers, optional output register
// - page decoder enables shared output driver
// - shared lines never fought nor floating
// - ten local outputs, nine distinct
// - read and write on unrelated clocks
// - write clock writes, read clock reads
// - per-side enable and clear, read/write mode
// - input clock for inputs, output clock out
// - per-side enable and clear, input/output mode
// - memory registers clear from local or global
// - chip-wide clear overrides everything
module embpt_block (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] pt_in,
  input  wire logic [1:0]  blk_clk,
  input  wire logic [1:0]  blk_ena,
  input  wire logic [1:0]  clr_local,
  input  wire logic [1:0]  clr_global,
  input  wire logic        chip_wide_clear_n,
  input  wire logic [15:0] mem_wdata,
  input  wire logic [10:0] mem_waddr,
  input  wire logic        mem_we,
  input  wire logic [10:0] mem_raddr,
  input  wire logic        fetch_strobe,
  input  wire logic [1:0]  mem_page,
  output logic      [15:0] blk_out,
  output logic             blk_oe_n,
  output logic      [9:0]  local_out
);

  embpt_pkg::embpt_state_t st_q;
  embpt_pkg::embpt_state_t st_d;
  logic [1:0]  edg;
  logic [1:0]  clr;
  logic        cwc;
  logic [8:0]  fb;
  logic [31:0] pt;
  logic [15:0] pa;
  logic [15:0] pb;
  logic [15:0] chain;
  logic [15:0] sum;
  logic [15:0] mc_hit;
  logic [15:0] mc_clr;
  logic        cy;
  logic [2:0]  ws;
  logic [4:0]  wdt;
  logic        wr_ce;
  logic        rd_ce;
  logic        rd_clr;
  logic        out_ce;
  logic        drive;
  logic        setup;
  logic        access;
  logic [31:0] rdv;
  logic        rerr;
  logic [4:0]  ptix;

  // ==========================================
  // memory addressing helpers
  function automatic logic [10:0] mbase(input logic [10:0] a,
                                        input logic [2:0]  s);
    unique case (s)
      3'h0:    return {a[6:0], 4'h0};
      3'h1:    return {a[7:0], 3'h0};
      3'h2:    return {a[8:0], 2'h0};
      3'h3:    return {a[9:0], 1'b0};
      default: return a;
    endcase
  endfunction : mbase

  function automatic logic [15:0] mrd(input logic [2047:0] m,
                                      input logic [10:0]   b,
                                      input logic [2:0]    s);
    logic [15:0] r;
    logic [4:0]  w;
    r = '0;
    w = embpt_pkg::WID_16 >> s;
    for (int k = 0; k < 16; k++) begin
      if (5'(k) < w) r[k] = m[11'(b + 11'(k))];
    end
    return r;
  endfunction : mrd

  // ==========================================
  // next state
  always_comb begin
    st_d = st_q;
    cy   = 1'b0;
    cwc  = ~chip_wide_clear_n;
    // feedback taken registered so combinational cells make no loop
    fb   = st_q.blk_out[8:0];
    for (int k = 0; k < 2; k++) begin
      edg[k] = st_q.ctrl.fall[k] ? (st_q.clk_prev[k] & ~blk_clk[k])
                                 : (~st_q.clk_prev[k] & blk_clk[k]);
    end
    st_d.clk_prev = blk_clk;
    clr = (clr_local ^ st_q.ctrl.inv) | clr_global;

    // empty mask means an unused term, not a constant one
    for (int j = 0; j < 32; j++) begin
      pt[j] = (|st_q.ptm[j])
            & (&(pt_in | ~st_q.ptm[j][0]))
            & (&(~pt_in | ~st_q.ptm[j][1]))
            & (&(fb | ~st_q.ptm[j][2][8:0]))
            & (&(~fb | ~st_q.ptm[j][2][24:16]));
    end

    // macrocells, expander chain runs upward through the block
    for (int i = 0; i < 16; i++) begin
      pa[i] = pt[2*i];
      pb[i] = pt[2*i+1] ^ st_q.mcfg[i].inv;
      chain[i] = (st_q.mcfg[i].exa & pa[i]) | (st_q.mcfg[i].exb & pb[i])
               | (st_q.mcfg[i].pass & cy);
      sum[i] = ((~st_q.mcfg[i].exa & pa[i]) | (~st_q.mcfg[i].exb & pb[i])
             | (st_q.mcfg[i].take & cy)) ^ st_q.mcfg[i].xr;
      cy = chain[i];
      mc_hit[i] = edg[st_q.mcfg[i].clk] & blk_ena[st_q.mcfg[i].clk];
      mc_clr[i] = (st_q.mcfg[i].clr == 2'h1 & clr[0])
                | (st_q.mcfg[i].clr == 2'h2 & clr[1]);
      if (mc_hit[i]) begin
        unique case (st_q.mcfg[i].ff)
          embpt_pkg::FF_D:  st_d.mc_q[i] = sum[i];
          embpt_pkg::FF_T:  st_d.mc_q[i] = st_q.mc_q[i] ^ sum[i];
          embpt_pkg::FF_JK: st_d.mc_q[i] = (sum[i] & ~st_q.mc_q[i])
                                          | (~pb[i] & st_q.mc_q[i]);
          embpt_pkg::FF_SR: st_d.mc_q[i] = sum[i] | (~pb[i] & st_q.mc_q[i]);
        endcase
      end
      if (mc_clr[i]) st_d.mc_q[i] = 1'b0;
    end

    // ==========================================
    // memory mode
    ws     = (st_q.ctrl.wid > embpt_pkg::WID_MAX) ? embpt_pkg::WID_MAX
                                                  : st_q.ctrl.wid;
    wdt    = embpt_pkg::WID_16 >> ws;
    wr_ce  = edg[0] & blk_ena[0];
    rd_ce  = st_q.ctrl.io ? (edg[0] & blk_ena[0])
                          : (edg[1] & blk_ena[1]);
    rd_clr = st_q.ctrl.io ? clr[0] : clr[1];
    out_ce = edg[1] & blk_ena[1];

    // internal write pulse one pclk after capture
    st_d.wr_go = 1'b0;
    if (st_q.wr_go) begin
      for (int k = 0; k < 16; k++) begin
        if (5'(k) < wdt) begin
          st_d.mem[11'(mbase(st_q.wr_addr, ws) + 11'(k))] =
            st_q.wr_data[k];
        end
      end
    end
    if (wr_ce) begin
      st_d.wr_addr = mem_waddr;
      st_d.wr_data = mem_wdata;
      st_d.wr_go   = mem_we & st_q.ctrl.mem;
    end
    if (clr[0]) begin
      st_d.wr_addr = '0;
      st_d.wr_data = '0;
      st_d.wr_go   = 1'b0;
    end
    // array read from the old contents gives the old word
    if (rd_ce & fetch_strobe) begin
      st_d.rd_addr = mem_raddr;
      st_d.rd_page = mem_page;
      st_d.rd_word = mrd(st_q.mem, mbase(mem_raddr, ws), ws);
    end
    if (rd_clr) begin
      st_d.rd_addr = '0;
      st_d.rd_page = '0;
      st_d.rd_word = '0;
    end
    if (out_ce) st_d.dout = st_q.rd_word;
    if (clr[1]) st_d.dout = '0;

    if (cwc) begin
      st_d.mc_q    = '0;
      st_d.wr_addr = '0;
      st_d.wr_data = '0;
      st_d.wr_go   = 1'b0;
      st_d.rd_addr = '0;
      st_d.rd_page = '0;
      st_d.rd_word = '0;
      st_d.dout    = '0;
    end

    // ==========================================
    // outputs
    drive = ~st_q.ctrl.mem | ~st_q.ctrl.deep
          | (st_d.rd_page == st_q.ctrl.page);
    st_d.blk_oe_n = ~drive;
    for (int i = 0; i < 16; i++) begin
      st_d.blk_out[i] = st_q.mcfg[i].seq ? st_d.mc_q[i] : sum[i];
    end
    if (st_q.ctrl.mem) begin
      st_d.blk_out = ~drive ? 16'h0000
                   : st_q.ctrl.oreg ? st_d.dout : st_d.rd_word;
    end
    st_d.local_out = {st_d.blk_out[0], st_d.blk_out[8:0]};

    // ==========================================
    // apb slave, no wait states
    setup  = psel & ~penable;
    access = psel & penable & st_q.pready;
    ptix   = 5'(paddr[9:4] - embpt_pkg::PT_BASE);
    rdv    = '0;
    rerr   = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      rerr = 1'b1;
    end else if (paddr == embpt_pkg::A_CTRL) begin
      rdv = 32'(st_q.ctrl);
    end else if (paddr[11:6] == embpt_pkg::A_MCFG[11:6]) begin
      rdv = 32'(st_q.mcfg[paddr[5:2]]);
    end else if (paddr == embpt_pkg::A_STAT) begin
      rdv = {st_q.rd_word, st_q.mc_q};
    end else if (paddr >= embpt_pkg::A_PTM && paddr < embpt_pkg::A_PTEND
                 && paddr[3:2] != 2'h3) begin
      rdv = st_q.ptm[ptix][paddr[3:2]];
    end else begin
      rerr = 1'b1;
    end
    st_d.pready  = setup;
    st_d.pslverr = setup & rerr;
    if (setup) st_d.prdata = rdv;
    if (access & pwrite & ~st_q.pslverr) begin
      if (paddr == embpt_pkg::A_CTRL) begin
        st_d.ctrl = embpt_pkg::embpt_ctrl_t'(pwdata[embpt_pkg::CTRL_W-1:0]);
      end else if (paddr[11:6] == embpt_pkg::A_MCFG[11:6]) begin
        st_d.mcfg[paddr[5:2]] =
          embpt_pkg::embpt_mcfg_t'(pwdata[embpt_pkg::MCFG_W-1:0]);
      end else if (paddr >= embpt_pkg::A_PTM) begin
        st_d.ptm[ptix][paddr[3:2]] = pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_q <= '0;
    else          st_q <= st_d;
  end

  assign prdata    = st_q.prdata;
  assign pready    = st_q.pready;
  assign pslverr   = st_q.pslverr;
  assign blk_out   = st_q.blk_out;
  assign blk_oe_n  = st_q.blk_oe_n;
  assign local_out = st_q.local_out;

  // ==========================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  property p_apb;
    s_setup |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb ready timing");

  property p_cwc;
    !chip_wide_clear_n |=> st_q.mc_q == 16'h0000 && !st_q.wr_go
                           && st_q.dout == 16'h0000;
  endproperty
  a_cwc: assert property (p_cwc) else $error("chip clear ignored");

  property p_comb;
    !st_q.ctrl.mem && !st_q.mcfg[0].seq |=> blk_out[0] == $past(sum[0]);
  endproperty
  a_comb: assert property (p_comb) else $error("bypass path wrong");

  property p_hold;
    !mc_hit[0] && !mc_clr[0] && chip_wide_clear_n |=> $stable(st_q.mc_q[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("cell moved w/o clock");

  property p_dff;
    mc_hit[0] && !mc_clr[0] && chip_wide_clear_n
      && st_q.mcfg[0].ff == embpt_pkg::FF_D |=> st_q.mc_q[0] == $past(sum[0]);
  endproperty
  a_dff: assert property (p_dff) else $error("d capture wrong");

  property p_page;
    !drive |=> blk_oe_n && blk_out == 16'h0000;
  endproperty
  a_page: assert property (p_page) else $error("driver not off");

  property p_float;
    !st_q.ctrl.deep || !st_q.ctrl.mem |=> !blk_oe_n;
  endproperty
  a_float: assert property (p_float) else $error("line left floating");

  sequence s_wcap;
    wr_ce && mem_we && st_q.ctrl.mem && st_q.ctrl.wid == 3'h0 && !clr[0]
      && chip_wide_clear_n;
  endsequence
  property p_write;
    s_wcap |=> st_q.wr_go ##1
      mrd(st_q.mem, mbase($past(mem_waddr, 2), 3'h0), 3'h0)
        == $past(mem_wdata, 2);
  endproperty
  a_write: assert property (p_write) else $error("write lost");

  property p_rbw;
    s_wcap and (rd_ce && fetch_strobe && !rd_clr && mem_raddr == mem_waddr)
      |=> st_q.rd_word == $past(mrd(st_q.mem, mbase(mem_raddr, 3'h0), 3'h0));
  endproperty
  a_rbw: assert property (p_rbw) else $error("read not old word");

  property p_oreg;
    st_q.ctrl.mem && st_q.ctrl.oreg && drive |=> blk_out == st_q.dout;
  endproperty
  a_oreg: assert property (p_oreg) else $error("output reg bypassed");

  property p_io;
    st_q.ctrl.io && edg[0] && blk_ena[0] && fetch_strobe && !clr[0]
      && chip_wide_clear_n |=> st_q.rd_addr == $past(mem_raddr);
  endproperty
  a_io: assert property (p_io) else $error("io read addr missed");

  property p_rw;
    !st_q.ctrl.io && edg[0] && !edg[1] && !clr[1] |=> $stable(st_q.rd_addr);
  endproperty
  a_rw: assert property (p_rw) else $error("read side on write clk");

  property p_local;
    local_out[9] == local_out[0] && local_out[8:0] == blk_out[8:0];
  endproperty
  a_local: assert property (p_local) else $error("local outs wrong");

  // a cell that picked a clear line must read zero after it
  property p_cclr;
    mc_clr[0] && chip_wide_clear_n |=> !st_q.mc_q[0];
  endproperty
  a_cclr: assert property (p_cclr) else $error("cell clear ignored");

  property p_wclr;
    clr[0] |=> !st_q.wr_go && st_q.wr_addr == 11'h000;
  endproperty
  a_wclr: assert property (p_wclr) else $error("write side not cleared");

  property p_rclr;
    !st_q.ctrl.io && clr[1] |=> st_q.rd_word == 16'h0000 && st_q.dout == 16'h0000;
  endproperty
  a_rclr: assert property (p_rclr) else $error("read side not cleared");

  // read word may only move on its own clock, a clear or chip clear
  property p_rhold;
    !st_q.ctrl.io && !(edg[1] && blk_ena[1]) && !rd_clr && chip_wide_clear_n
      |=> $stable(st_q.rd_word);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read word moved");

endmodule : embpt_block

// ### embpt_user_logic.sv
`timescale 1ns/1ps
// ==========================================
// far-side user logic: turns bench requests into block clock pulses
module embpt_user_logic (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] tick,
  output logic      [1:0] blk_clk
);
  // clocks idle low outside pulses; data stays put around each edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_clk <= 2'h0;
    end else begin
      blk_clk <= tick;
    end
  end
endmodule : embpt_user_logic

// ### test_embpt_block.sv
`timescale 1ns/1ps
module test_embpt_block;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, blk_oe_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pt_in, rd, bad_count, checks;
  logic [1:0]  blk_clk, blk_ena, clr_global, clr_local, tick, mem_page;
  logic        chip_wide_clear_n, mem_we, fetch_strobe, err;
  logic [15:0] mem_wdata, blk_out;
  logic [10:0] mem_waddr, mem_raddr;
  logic [9:0]  local_out;

  embpt_user_logic PART (.pclk(pclk), .presetn(presetn), .tick(tick), .blk_clk(blk_clk));
  embpt_block DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pt_in(pt_in), .blk_clk(blk_clk), .blk_ena(blk_ena),
    .clr_local(clr_local), .clr_global(clr_global), .chip_wide_clear_n(chip_wide_clear_n),
    .mem_wdata(mem_wdata), .mem_waddr(mem_waddr), .mem_we(mem_we), .mem_raddr(mem_raddr),
    .fetch_strobe(fetch_strobe), .mem_page(mem_page), .blk_out(blk_out),
    .blk_oe_n(blk_oe_n), .local_out(local_out));

  // ==========================================
  // clock, reset, watchdog
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count = bad_count + 1;
    tally_and_finish();
  end

  // ==========================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks = checks + 1;
    if (got !== ex) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // apb transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n = n + 1;
      @(posedge pclk);
    end
    if (n >= 20) bad_count = bad_count + 1;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic pulse(input logic [1:0] m);
    @(posedge pclk);
    tick <= m;
    repeat (2) @(posedge pclk);
    tick <= 2'h0;
    repeat (5) @(posedge pclk);
  endtask : pulse

  task automatic mem_op(input logic w, input logic r, input logic [10:0] a, input logic [15:0] d);
    @(posedge pclk);
    mem_waddr <= a; mem_raddr <= a; mem_wdata <= d; mem_we <= w; fetch_strobe <= r;
    pulse({r, w});
    mem_we <= 1'b0; fetch_strobe <= 1'b0;
  endtask : mem_op

  task automatic tally_and_finish();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================
  // tests
  initial begin
    bad_count = 0; checks = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; pt_in = 32'h0; blk_ena = 2'h3; clr_global = 2'h0; tick = 2'h0;
    clr_local = 2'h0;
    mem_page = 2'h0; chip_wide_clear_n = 1'b1; mem_we = 1'b0; fetch_strobe = 1'b0;
    mem_wdata = 16'h0; mem_waddr = 11'h0; mem_raddr = 11'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk("out_rst", 32'h0, {blk_oe_n, local_out, blk_out});
    apb(1'b0, 12'h300, 32'h0);
    chk("err_unmapped", 32'h1, err);
    apb(1'b0, 12'h002, 32'h0);
    chk("err_unaligned", 32'h1, err);
    apb(1'b1, embpt_pkg::A_STAT, 32'hffff_ffff);
    chk("stat_wr_err", 32'h0, err);
    // product term: cell 0 term a = pt_in[0], combinational
    apb(1'b1, embpt_pkg::A_PTM, 32'h1);
    apb(1'b0, embpt_pkg::A_PTM, 32'h0);
    chk("ptm_rd", 32'h1, rd);
    pt_in <= 32'h1;
    repeat (4) @(posedge pclk);
    chk("comb_out", 32'h1, blk_out[0]);
    chk("local_fb", 32'h3, {local_out[9], local_out[0]});
    pt_in <= 32'h0;
    repeat (4) @(posedge pclk);
    chk("comb_low", 32'h0, blk_out[0]);
    // registered D cell on clock 0, clear 0
    apb(1'b1, embpt_pkg::A_MCFG, 32'h11);
    pt_in <= 32'h1;
    pulse(2'h1);
    chk("dff_load", 32'h1, blk_out[0]);
    pt_in <= 32'h0;
    blk_ena <= 2'h2;
    pulse(2'h1);
    chk("ena_off_hold", 32'h1, blk_out[0]);
    blk_ena <= 2'h3;
    clr_global <= 2'h1;
    repeat (3) @(posedge pclk);
    clr_global <= 2'h0;
    repeat (2) @(posedge pclk);
    chk("clr0", 32'h0, blk_out[0]);
    pt_in <= 32'h1;
    pulse(2'h1);
    chk("dff_reload", 32'h1, blk_out[0]);
    clr_local <= 2'h1;
    repeat (3) @(posedge pclk);
    clr_local <= 2'h0;
    pt_in <= 32'h0;
    repeat (2) @(posedge pclk);
    chk("clr_local", 32'h0, blk_out[0]);
    // memory x16, read/write clocks
    apb(1'b1, embpt_pkg::A_CTRL, 32'h1);
    mem_op(1'b1, 1'b0, 11'h005, 16'ha5c3);
    mem_op(1'b0, 1'b1, 11'h005, 16'h0);
    chk("mem_rd", 32'ha5c3, blk_out);
    mem_op(1'b1, 1'b1, 11'h005, 16'h1234);
    chk("same_edge_old", 32'ha5c3, blk_out);
    mem_op(1'b0, 1'b1, 11'h005, 16'h0);
    chk("mem_new", 32'h1234, blk_out);
    // x8 width keeps the low byte
    apb(1'b1, embpt_pkg::A_CTRL, 32'h3);
    mem_op(1'b1, 1'b0, 11'h007, 16'hbeef);
    mem_op(1'b0, 1'b1, 11'h007, 16'h0);
    chk("mem_x8", 32'hef, blk_out[7:0]);
    // deep mode, this block owns page 1
    apb(1'b1, embpt_pkg::A_CTRL, 32'h501);
    mem_page <= 2'h1;
    mem_op(1'b0, 1'b1, 11'h005, 16'h0);
    chk("page_hit", 32'h1234, {blk_oe_n, blk_out});
    mem_page <= 2'h2;
    mem_op(1'b0, 1'b1, 11'h005, 16'h0);
    chk("page_miss", 32'h10000, {blk_oe_n, blk_out});
    mem_page <= 2'h1;
    mem_op(1'b0, 1'b1, 11'h005, 16'h0);
    chip_wide_clear_n <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("chip_clear", 32'h10000, {blk_oe_n, blk_out});
    chip_wide_clear_n <= 1'b1;
    // output register: first read shows the cleared word, second the stored one
    apb(1'b1, embpt_pkg::A_CTRL, 32'h21);
    mem_op(1'b0, 1'b1, 11'h005, 16'h0);
    chk("oreg_pipe", 32'h0, blk_out);
    mem_op(1'b0, 1'b1, 11'h005, 16'h0);
    chk("oreg_out", 32'h1234, blk_out);
    // input/output mode reads on clock 0
    apb(1'b1, embpt_pkg::A_CTRL, 32'h11);
    mem_raddr <= 11'h003;
    fetch_strobe <= 1'b1;
    pulse(2'h1);
    fetch_strobe <= 1'b0;
    chk("io_rd", 32'hef00, blk_out);
    tally_and_finish();
  end
endmodule : test_embpt_block
